// ===== pwm_edge_pkg.sv
// shared constants and mode encodings for the pulse modulator edge generator
package pwm_edge_pkg;

  // default width of the period counter and of every time word
  localparam int CNT_W_DEF = 14;

  // period counter restarts from this value
  localparam int CNT_START = 0;

  // reset value of every one-bit output and edge flop
  localparam logic OUT_RST = 1'b0;

  // edge equation selection
  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'h0,
    MODE_MULTI      = 3'h1,
    MODE_RESONANT   = 3'h2,
    MODE_TRIANGULAR = 3'h3,
    MODE_LEADING    = 3'h4
  } mode_t;

  // adaptive sample trigger form
  typedef enum logic {
    ADAPT_END    = 1'b0,
    ADAPT_CENTER = 1'b1
  } adapt_sel_t;

  // phase trigger source
  typedef enum logic {
    PHASE_FROM_REG  = 1'b0,
    PHASE_FROM_DUTY = 1'b1
  } phase_src_t;

endpackage

// ===== pwm_mode_edge_generator.sv
// edge generator for one pulse_modulator with outputs output_a and output_b
// What this block does
// R1 - period counter counts from zero up to period_limit, then restarts
// R2 - every output or trigger changes when the counter equals its target
// R3 - normal: output_a rises at event1, falls at event1 + duty + adjust a
// R4 - normal: output_b rises at a fall + (event3 - event2), falls event4
// R5 - normal/multi: adaptive trigger at event1 + duty (or duty/2) + offset
// R6 - normal: cycle adjust b affects no edge
// R7 - sample triggers and blanking windows come straight from their settings
// R8 - phase trigger time is the phase setting or the loop duty
// R9 - multi: a as normal, b rises event3, falls event3 + duty + adjust b
// R10 - multi: event2 and event4 are ignored
// R11 - multi: b keeps its width across the period end; a never wraps
// R12 - resonant: average dead time subtracted from duty for both outputs
// R13 - resonant: b rise and fall built from duty, dead times, loop period
// R14 - filter supplies a loop period equal to twice its duty
// R15 - resonant: only output_a rising edge is fixed, at event1
// R16 - triangular: output_a and adaptive trigger stay quiet
// R17 - triangular: b centred on half period, adjusts a and b on its edges
// R18 - leading: a falls at event1, rises at event1 - duty + adjust a
// R19 - leading: b rises event4, falls at a rise - (event2 - event3)
// R20 - leading: adaptive trigger at event1 - duty (or duty/2) + offset
// R21 - mode setting picks one edge equation set plus adaptive form
`timescale 1ns/1ps
`default_nettype none

module pwm_mode_edge_generator #(
  parameter int W = pwm_edge_pkg::CNT_W_DEF
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // mode configuration
  input  wire pwm_edge_pkg::mode_t       mode_sel,
  input  wire pwm_edge_pkg::adapt_sel_t  adapt_sel,
  input  wire pwm_edge_pkg::phase_src_t  phase_src,
  // period and event settings
  input  wire logic [W-1:0]              period_limit,
  input  wire logic [W-1:0]              event1,
  input  wire logic [W-1:0]              event2,
  input  wire logic [W-1:0]              event3,
  input  wire logic [W-1:0]              event4,
  // signed adjusts
  input  wire logic signed [W-1:0]       cycle_adj_a,
  input  wire logic signed [W-1:0]       cycle_adj_b,
  input  wire logic signed [W-1:0]       sample_offset,
  // fixed-time settings
  input  wire logic [W-1:0]              phase_value,
  input  wire logic [W-1:0]              sample1_time,
  input  wire logic [W-1:0]              sample2_time,
  input  wire logic [W-1:0]              blank_a_begin,
  input  wire logic [W-1:0]              blank_a_end,
  input  wire logic [W-1:0]              blank_b_begin,
  input  wire logic [W-1:0]              blank_b_end,
  // loop compensation filter
  input  wire logic [W-1:0]              loop_duty,
  input  wire logic [W-1:0]              loop_period,
  // outputs
  output var  logic                      output_a,
  output var  logic                      output_b,
  output var  logic                      adapt_trig,
  output var  logic                      sample_trig1,
  output var  logic                      sample_trig2,
  output var  logic                      blank_a,
  output var  logic                      blank_b,
  output var  logic                      phase_trig,
  output var  logic                      period_start,
  output var  logic [W-1:0]              count
);
  import pwm_edge_pkg::*;

  // two guard bits hold sums and negative differences
  localparam int XW = W + 2;
  typedef logic signed [XW-1:0] ext_t;
  localparam ext_t ONE = ext_t'(1);

  // zero-extended copy of an unsigned time word
  function automatic ext_t u(input logic [W-1:0] v);
    return $signed({2'b00, v});
  endfunction

  // sign-extended copy of an adjust word
  function automatic ext_t s(input logic signed [W-1:0] v);
    return ext_t'(v);
  endfunction

  // out-of-range targets pinned to the period ends
  function automatic logic [W-1:0] clamp(input ext_t v, input ext_t lim);
    logic [W-1:0] r;
    if (v < 0) begin
      r = '0;
    end else if (v > lim) begin
      r = lim[W-1:0];
    end else begin
      r = v[W-1:0];
    end
    return r;
  endfunction

  // folds a target back into the period, used where a pulse may cross the end
  // one fold only: a target beyond two periods is not brought back in range
  function automatic logic [W-1:0] wrap(input ext_t v, input ext_t lim);
    ext_t span;
    ext_t r;
    span = lim + ONE;
    r    = v;
    if (v > lim) begin
      r = v - span;
    end else if (v < 0) begin
      r = v + span;
    end
    return r[W-1:0];
  endfunction

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         wrap_now;

  // edge targets
  logic [W-1:0] a_rise;
  logic [W-1:0] a_fall;
  logic [W-1:0] b_rise;
  logic [W-1:0] b_fall;
  logic [W-1:0] adapt_t;
  logic [W-1:0] phase_t;
  // only output_a and the adaptive trigger can be switched off
  logic         a_en;
  logic         adapt_en;
  logic         b_full;

  // shared terms
  ext_t lim;
  ext_t duty;
  ext_t half_duty;
  ext_t e1;
  ext_t dt1;
  ext_t dt2;
  ext_t avg_dead;
  ext_t a_fall_x;
  ext_t a_rise_x;
  ext_t adapt_base;
  ext_t width_b;

  assign lim       = u(period_limit);
  assign duty      = u(loop_duty);
  assign half_duty = u(loop_duty >> 1);
  assign e1        = u(event1);
  // dead time after a falls, and the one from b falling round to a rising
  assign dt1       = u(event3) - u(event2);
  assign dt2       = lim - u(event4) + e1;
  assign avg_dead  = (dt1 + dt2) >>> 1;
  assign width_b   = duty + s(cycle_adj_b);

  // period counter
  // >= so that lowering period_limit below the count wraps at the next edge
  assign wrap_now = (cnt_q >= period_limit);
  assign cnt_d    = wrap_now ? W'(CNT_START) : cnt_q + 1'b1; // R1

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= W'(CNT_START);
    end else begin
      cnt_q <= cnt_d; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_start <= OUT_RST;
    end else begin
      period_start <= wrap_now;
    end
  end

  assign count = cnt_q;

  // edge equations per mode
  // every target is worked out in XW bits so that differences of event
  // times and signed adjusts can go negative before they are pinned;
  // a target pinned to zero or period_limit still gives an edge there,
  // so a very short or very long pulse sits at the period end rather
  // than vanishing
  always_comb begin
    a_fall_x   = '0;
    a_rise_x   = '0;
    adapt_base = '0;
    a_rise     = '0;
    a_fall     = '0;
    b_rise     = '0;
    b_fall     = '0;
    a_en       = 1'b1;
    adapt_en   = 1'b1;
    b_full     = 1'b0;
    case (mode_sel) // R21
      MODE_MULTI: begin
        // event2 and event4 play no part in this mode
        a_fall_x   = e1 + duty + s(cycle_adj_a);
        a_rise     = event1; // R9
        a_fall     = clamp(a_fall_x, lim); // R11
        b_rise     = event3; // R9
        b_fall     = wrap(u(event3) + width_b, lim); // R11
        b_full     = (width_b > lim); // R11
        adapt_base = e1; // R5
      end
      MODE_RESONANT: begin
        // average dead time is floored when the two dead times differ by an odd count
        a_fall_x   = e1 + duty - avg_dead + s(cycle_adj_a); // R12
        a_rise     = event1; // R15
        a_fall     = clamp(a_fall_x, lim);
        b_rise     = clamp(e1 + duty - avg_dead + dt1, lim); // R13
        b_fall     = clamp(u(loop_period) - (lim - u(event4)), lim); // R13
        adapt_base = e1;
      end
      MODE_TRIANGULAR: begin
        // half period is floored, so an odd period_limit puts the centre half a count early
        a_en       = 1'b0; // R16
        adapt_en   = 1'b0; // R16
        b_rise     = clamp((lim >>> 1) - half_duty + s(cycle_adj_a), lim); // R17
        b_fall     = clamp((lim >>> 1) + half_duty + s(cycle_adj_b), lim); // R17
      end
      MODE_LEADING: begin
        // normal mode mirrored: fixed falling edge at event1, moving rising edge
        a_rise_x   = e1 - duty + s(cycle_adj_a);
        a_fall     = event1; // R18
        a_rise     = clamp(a_rise_x, lim); // R18
        b_rise     = event4; // R19
        b_fall     = clamp(a_rise_x - (u(event2) - u(event3)), lim); // R19
        adapt_base = e1;
      end
      default: begin
        // normal mode; cycle_adj_b deliberately left out
        a_fall_x   = e1 + duty + s(cycle_adj_a); // R3 R6
        a_rise     = event1; // R3
        a_fall     = clamp(a_fall_x, lim); // R3
        b_rise     = clamp(a_fall_x + dt1, lim); // R4
        b_fall     = event4; // R4
        adapt_base = e1;
      end
    endcase
  end

  // adaptive sample trigger; leading mode counts backwards from event1
  // a target pinned to a period end still fires once per period
  always_comb begin
    adapt_t = '0;
    if (mode_sel == MODE_LEADING) begin
      if (adapt_sel == ADAPT_CENTER) begin
        adapt_t = clamp(adapt_base - half_duty + s(sample_offset), lim); // R20
      end else begin
        adapt_t = clamp(adapt_base - duty + s(sample_offset), lim); // R20
      end
    end else begin
      if (adapt_sel == ADAPT_CENTER) begin
        adapt_t = clamp(adapt_base + half_duty + s(sample_offset), lim); // R5
      end else begin
        adapt_t = clamp(adapt_base + duty + s(sample_offset), lim); // R5
      end
    end
  end

  // taking the phase from loop_duty lets the filter steer the offset between modulators
  assign phase_t = (phase_src == PHASE_FROM_DUTY) ? loop_duty : phase_value; // R8

  // output_a: equal rise and fall gives no pulse rather than a glitch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_a <= OUT_RST;
    end else if (!a_en) begin
      output_a <= 1'b0; // R16
    end else if (cnt_q == a_fall) begin
      output_a <= 1'b0; // R2
    end else if (cnt_q == a_rise) begin
      output_a <= 1'b1; // R2
    end
  end

  // output_b: set and clear by compare, held high while b_full, so a wrapped pulse stays intact
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_b <= OUT_RST;
    end else if (b_full) begin
      output_b <= 1'b1; // R11
    end else if (cnt_q == b_fall) begin
      output_b <= 1'b0; // R2
    end else if (cnt_q == b_rise) begin
      output_b <= 1'b1; // R2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adapt_trig <= OUT_RST;
    end else begin
      adapt_trig <= adapt_en && (cnt_q == adapt_t); // R2 R16
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_trig <= OUT_RST;
    end else begin
      phase_trig <= (cnt_q == phase_t); // R8
    end
  end

  // fixed-time triggers, identical in every mode
  // they keep running while output_a is held off in triangular mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_trig1 <= OUT_RST;
      sample_trig2 <= OUT_RST;
    end else begin
      sample_trig1 <= (cnt_q == sample1_time); // R7
      sample_trig2 <= (cnt_q == sample2_time); // R7
    end
  end

  // blanking windows; end wins when begin and end coincide
  // a window whose end precedes its begin spans the period end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blank_a <= OUT_RST;
    end else if (cnt_q == blank_a_end) begin
      blank_a <= 1'b0; // R7
    end else if (cnt_q == blank_a_begin) begin
      blank_a <= 1'b1; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blank_b <= OUT_RST;
    end else if (cnt_q == blank_b_end) begin
      blank_b <= 1'b0; // R7
    end else if (cnt_q == blank_b_begin) begin
      blank_b <= 1'b1; // R7
    end
  end

  // the resonant equations assume loop_period = 2 * loop_duty upstream (R14);
  // nothing here checks it, a wrong filter setup just skews output_b

endmodule

`default_nettype wire

// ===== pwm_edge_asserts.sv
// port assertions and covers for the pulse modulator edge generator
`timescale 1ns/1ps
`default_nettype none
module pwm_edge_asserts
  import pwm_edge_pkg::*;
#(
  parameter int W = 14
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // settings
  input wire mode_t        mode_sel,
  input wire phase_src_t   phase_src,
  input wire logic [W-1:0] period_limit,
  input wire logic [W-1:0] event1,
  input wire logic [W-1:0] event3,
  input wire logic [W-1:0] phase_value,
  input wire logic [W-1:0] sample1_time,
  input wire logic [W-1:0] sample2_time,
  input wire logic [W-1:0] blank_a_begin,
  input wire logic [W-1:0] blank_a_end,
  input wire logic [W-1:0] loop_duty,
  // outputs
  input wire logic         output_a,
  input wire logic         output_b,
  input wire logic         adapt_trig,
  input wire logic         sample_trig1,
  input wire logic         sample_trig2,
  input wire logic         blank_a,
  input wire logic         phase_trig,
  input wire logic         period_start,
  input wire logic [W-1:0] count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_cnt_inc;
    count < period_limit |=> count == $past(count) + 1'b1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count did not step");
  property p_cnt_wrap;
    count == period_limit |=> count == '0 && period_start;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("count did not wrap");
  property p_smp1;
    count == sample1_time |=> sample_trig1;
  endproperty
  a_smp1: assert property (p_smp1) else $error("sample trigger 1 missing");
  property p_smp2;
    count == sample2_time |=> sample_trig2 ##1 !sample_trig2;
  endproperty
  a_smp2: assert property (p_smp2) else $error("sample trigger 2 wrong");
  property p_blank;
    count == blank_a_begin && blank_a_end != blank_a_begin |=> blank_a;
  endproperty
  a_blank: assert property (p_blank) else $error("blank a not opened");
  property p_phase;
    count == (phase_src == PHASE_FROM_DUTY ? loop_duty : phase_value) |=> phase_trig;
  endproperty
  a_phase: assert property (p_phase) else $error("phase trigger missing");
  property p_tri;
    (mode_sel == MODE_TRIANGULAR) [*2] |-> !output_a && !adapt_trig;
  endproperty
  a_tri: assert property (p_tri) else $error("output a active in triangular");
  property p_multi_b;
    mode_sel == MODE_MULTI && count == event3 |=> output_b;
  endproperty
  a_multi_b: assert property (p_multi_b) else $error("multi b did not rise");
  property p_norm_a;
    mode_sel == MODE_NORMAL && count == event1 && loop_duty != '0 |=> output_a;
  endproperty
  a_norm_a: assert property (p_norm_a) else $error("normal a did not rise");
  c_multi: cover property (mode_sel == MODE_MULTI && $rose(output_b));
  c_tri: cover property (mode_sel == MODE_TRIANGULAR && $fell(output_b));
  c_lead: cover property (mode_sel == MODE_LEADING && $rose(output_a));
endmodule
bind pwm_mode_edge_generator pwm_edge_asserts #(.W(W)) chk (.clk, .sys_rst, .mode_sel,
  .phase_src, .period_limit, .event1, .event3, .phase_value, .sample1_time, .sample2_time,
  .blank_a_begin, .blank_a_end, .loop_duty, .output_a, .output_b, .adapt_trig,
  .sample_trig1, .sample_trig2, .blank_a, .phase_trig, .period_start, .count);
`default_nettype wire

// ===== loop_filter_model.sv
// loop filter stand-in: duty word, period word at twice the duty
`timescale 1ns/1ps
`default_nettype none
module loop_filter_model (
  // clock and control
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [13:0] target,
  // filter outputs
  output var  logic [13:0] loop_duty,
  output var  logic [13:0] loop_period
);
  // slow answer ramps up one step a cycle, as a filter settling would; a lower target is taken at once
  always_ff @(posedge clk) begin
    if (!slow || loop_duty > target)
      loop_duty <= target;
    else if (loop_duty < target)
      loop_duty <= loop_duty + 14'h1;
  end
  assign loop_period = {loop_duty[12:0], 1'b0};
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the pulse modulator edge generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pwm_edge_pkg::*;
  localparam int W = 14;
  localparam logic [W-1:0] NONE = 14'h3fff;
  logic clk, sys_rst, slow;
  mode_t mode_sel;
  adapt_sel_t adapt_sel;
  phase_src_t phase_src;
  logic [W-1:0] period_limit, event1, event2, event3, event4, phase_value, count;
  logic [W-1:0] sample1_time, sample2_time, blank_a_begin, blank_a_end, blank_b_begin;
  logic [W-1:0] blank_b_end, target, loop_duty, loop_period;
  logic signed [W-1:0] cycle_adj_a, cycle_adj_b, sample_offset;
  logic output_a, output_b, adapt_trig, sample_trig1, sample_trig2;
  logic blank_a, blank_b, phase_trig, period_start;
  logic [7:0] sig, prev;
  logic [W-1:0] rise [8];
  logic [W-1:0] fall [8];
  int err_total = 0;
  int tests_run = 0;
  assign sig = {blank_b, blank_a, sample_trig2, sample_trig1, phase_trig, adapt_trig,
                output_b, output_a};
  pwm_mode_edge_generator #(.W(W)) dut (.clk, .sys_rst, .mode_sel, .adapt_sel, .phase_src,
    .period_limit, .event1, .event2, .event3, .event4, .cycle_adj_a, .cycle_adj_b,
    .sample_offset, .phase_value, .sample1_time, .sample2_time, .blank_a_begin,
    .blank_a_end, .blank_b_begin, .blank_b_end, .loop_duty, .loop_period, .output_a,
    .output_b, .adapt_trig, .sample_trig1, .sample_trig2, .blank_a, .blank_b,
    .phase_trig, .period_start, .count);
  loop_filter_model filt (.clk, .slow, .target, .loop_duty, .loop_period);
  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // edges land one cycle after the match, so counts seen are target + 1
  task automatic measure();
    int n;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (period_start !== 1'b1 && n < 100);
    end
    prev = sig;
    for (int k = 0; k < 8; k++) begin
      rise[k] = NONE;
      fall[k] = NONE;
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 8; k++) begin
        if (sig[k] && !prev[k]) rise[k] = count;
        if (!sig[k] && prev[k]) fall[k] = count;
      end
      prev = sig;
    end
  endtask
  task automatic t_normal();
    measure();
    check(rise[0], 14'h5);
    check(fall[0], 14'h11);
    check(rise[1], 14'h14);
    check(fall[1], 14'h25);
    check(rise[2], 14'h10);
    check(rise[3], 14'h8);
    check(rise[4], 14'h4);
    check(rise[5], 14'h22);
    check(rise[6], 14'h3);
    check(fall[6], 14'h7);
    check(rise[7], 14'hb);
    check(fall[7], 14'hd);
    adapt_sel = ADAPT_CENTER;
    phase_src = PHASE_FROM_DUTY;
    cycle_adj_b = 14'sh5;
    measure();
    check(rise[2], 14'hb);
    check(rise[3], 14'hb);
    check(rise[1], 14'h14);
    check(fall[1], 14'h25);
    phase_src = PHASE_FROM_REG;
  endtask
  task automatic t_multi();
    mode_sel = MODE_MULTI;
    adapt_sel = ADAPT_END;
    event2 = 14'h2;
    event4 = 14'h9;
    slow = 1'b1;
    target = 14'h1e;
    measure();
    check(rise[1], 14'h18);
    check(fall[1], 14'h13);
    check(fall[0], 14'h25);
    check(rise[2], 14'h24);
    target = 14'h26;
    measure();
    check(fall[0], 14'h0);
    check(fall[1], NONE);
    check({13'h0, output_b}, 14'h1);
    event2 = 14'h14;
    event4 = 14'h24;
    slow = 1'b0;
  endtask
  task automatic t_resonant();
    mode_sel = MODE_RESONANT;
    target = 14'h14;
    cycle_adj_a = 14'sh0;
    measure();
    check(rise[0], 14'h5);
    check(fall[0], 14'h14);
    check(rise[1], 14'h17);
    check(fall[1], 14'h26);
    cycle_adj_a = 14'sh2;
    target = 14'ha;
  endtask
  task automatic t_tri();
    mode_sel = MODE_TRIANGULAR;
    measure();
    check(rise[0], NONE);
    check(rise[2], NONE);
    check(rise[1], 14'h11);
    check(fall[1], 14'h1e);
  endtask
  task automatic t_lead();
    mode_sel = MODE_LEADING;
    event1 = 14'h1e;
    measure();
    check(rise[0], 14'h17);
    check(fall[0], 14'h1f);
    check(rise[1], 14'h25);
    check(fall[1], 14'h1a);
    check(rise[2], 14'h16);
    adapt_sel = ADAPT_CENTER;
    measure();
    check(rise[2], 14'h1b);
  endtask
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    slow = 1'b0;
    target = 14'ha;
    mode_sel = MODE_NORMAL;
    adapt_sel = ADAPT_END;
    phase_src = PHASE_FROM_REG;
    period_limit = 14'h27;
    {event1, event2, event3, event4} = {14'h4, 14'h14, 14'h17, 14'h24};
    {cycle_adj_a, cycle_adj_b, sample_offset} = {14'sh2, 14'sh0, 14'sh1};
    {phase_value, sample1_time, sample2_time} = {14'h7, 14'h3, 14'h21};
    {blank_a_begin, blank_a_end, blank_b_begin, blank_b_end} = {14'h2, 14'h6, 14'ha, 14'hc};
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check(count, 14'h0);
    check({6'h0, sig}, 14'h0);
    t_normal();
    t_multi();
    t_resonant();
    t_tri();
    t_lead();
    complete_run();
  end
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
